// *** private_parser.sv ***
/*
 Parser end: walks transport packets, PES packets, sections and descriptor
 loops arriving on the link and emits every private byte with a location tag.
 Assumes each unit starts with sop on its first byte and kind set for it.
*/
// The address map and the AHB-Lite slave port were left to the implementer.
// Contract
// - Take private payload after any adaptation field.
// - Adaptation private bytes only when flag set.
// - Adaptation length at most 183; bounds private count.
// - Sixteen PES header private bytes when flagged.
// - Producer avoids start prefix in private bytes.
// - Private stream one: full header, then payload.
// - Private stream two: three fields, then payload.
// - Descriptors: tag, length, body skipped or captured.
// - Descriptor tags 64 to 255 are private.
// - Short section: five fields, then private bytes.
// - Long section: full header, private, CRC.
// - A start prefix alone proves no header; the code takes private stream two on its prefix and stream id alone.
// - Sync emulation in at most 4 packets.
`timescale 1ns/1ps
module private_parser (
   input wire logic clk, // 20 MHz clock
   input wire logic rst_n, // sync reset, active low
   ts_link_if.prs lk, // link from the source
   output logic [7:0] priv_data, // extracted byte
   output logic priv_valid, // one-cycle strobe
   output ts_priv_pkg::src_e priv_src, // carriage location
   output logic frame_err // one-cycle unit error
);
   import ts_priv_pkg::*;

   // ----------
   // State
   // ----------
   typedef enum logic [4:0] {
      S_IDLE, S_DROP, S_SKIP, S_TS_HDR, S_AF_LEN, S_AF_FLAGS, S_AF_PLEN,
      S_AF_PRIV, S_AF_REST, S_TS_PAY, S_PES_HDR, S_PES_F1, S_PES_F2,
      S_PES_HLEN, S_PES_EXT, S_PES_PRIV, S_PES_HREST, S_PES_PAY,
      S_SEC_HDR, S_SEC_PRIV, S_SEC_CRC, S_DSC_TAG, S_DSC_LEN, S_DSC_BODY
   } st_e;

   st_e st_q, st_d, nxt_q, nxt_d, end_q, end_d;
   logic reg_q, reg_d;
   logic [11:0] rem_q, rem_d;
   logic [7:0] fld_q, fld_d, sid_q, sid_d, f2_q, f2_d;
   logic [2:0] idx_q, idx_d;
   logic [3:0] hi_q, hi_d;
   logic syn_q, syn_d, pay_q, pay_d, dpriv_q, dpriv_d, rdy_q;
   logic [7:0] odat_q, odat_d;
   logic oval_q, oval_d, err_q, err_d;
   src_e osrc_q, osrc_d;
   logic take;
   logic [7:0] b, sk;

   // ----------
   // Field length decoders
   // ----------
   function automatic logic [7:0] af_skip(input logic [7:0] f);
      af_skip = (f[4] ? PCR_LEN : 8'h00) + (f[3] ? PCR_LEN : 8'h00)
         + (f[2] ? SPLICE_LEN : 8'h00);
   endfunction

   function automatic logic [7:0] pes_skip(input logic [7:0] f);
      logic [7:0] n;
      n = (f[7:6] == 2'h3) ? PTS_DTS_LEN : (f[7:6] == 2'h2 ? PTS_LEN : 8'h00);
      n = n + (f[5] ? ESCR_LEN : 8'h00) + (f[4] ? ES_RATE_LEN : 8'h00);
      n = n + (f[3] ? TRICK_LEN : 8'h00) + (f[2] ? COPY_LEN : 8'h00);
      pes_skip = n + (f[1] ? PES_CRC_LEN : 8'h00);
   endfunction

   assign lk.ready = rdy_q;
   assign take = lk.valid & rdy_q;
   assign b = lk.data;
   assign priv_data = odat_q;
   assign priv_valid = oval_q;
   assign priv_src = osrc_q;
   assign frame_err = err_q;

   // ----------
   // Byte walker
   // ----------
   always_comb
   begin
      st_d = st_q;
      nxt_d = nxt_q;
      end_d = end_q;
      reg_d = reg_q;
      rem_d = rem_q;
      fld_d = fld_q;
      sid_d = sid_q;
      f2_d = f2_q;
      idx_d = idx_q;
      hi_d = hi_q;
      syn_d = syn_q;
      pay_d = pay_q;
      dpriv_d = dpriv_q;
      odat_d = b;
      oval_d = 1'b0;
      osrc_d = SRC_NONE;
      err_d = 1'b0;
      sk = 8'h00;
      if (take && lk.sop)
      begin
         // A new unit always restarts the walk, whatever state was left.
         reg_d = 1'b0;
         idx_d = 3'h1;
         case (lk.kind)
            KIND_TS: st_d = (b == SYNC_BYTE) ? S_TS_HDR : S_DROP;
            KIND_PES: st_d = (b == 8'h00) ? S_PES_HDR : S_DROP;
            KIND_SEC: st_d = S_SEC_HDR;
            default:
            begin
               dpriv_d = (b >= DESC_PRIV_MIN);
               st_d = S_DSC_LEN;
            end
         endcase
         err_d = (st_d == S_DROP);
      end
      else if (take)
      begin
         if (reg_q)
            rem_d = rem_q - 12'h001;
         case (st_q)
            S_SKIP:
            begin
               fld_d = fld_q - 8'h01;
               if (fld_q == 8'h01)
                  st_d = nxt_q;
            end
            S_TS_HDR:
            begin
               idx_d = idx_q + 3'h1;
               if (idx_q == 3'h3)
               begin
                  pay_d = b[4];
                  st_d = b[5] ? S_AF_LEN : (b[4] ? S_TS_PAY : S_IDLE);
               end
            end
            S_AF_LEN:
            begin
               if (b > AF_LEN_MAX)
               begin
                  st_d = S_DROP;
                  err_d = 1'b1;
               end
               else if (b == 8'h00)
                  st_d = pay_q ? S_TS_PAY : S_IDLE;
               else
               begin
                  reg_d = 1'b1;
                  rem_d = {4'h0, b};
                  end_d = pay_q ? S_TS_PAY : S_IDLE;
                  st_d = S_AF_FLAGS;
               end
            end
            S_AF_FLAGS:
            begin
               sk = af_skip(b);
               nxt_d = b[1] ? S_AF_PLEN : S_AF_REST;
               fld_d = sk;
               st_d = (sk != 8'h00) ? S_SKIP : nxt_d;
            end
            S_AF_PLEN:
            begin
               fld_d = b;
               st_d = (b == 8'h00) ? S_AF_REST : S_AF_PRIV;
            end
            S_AF_PRIV:
            begin
               oval_d = 1'b1;
               osrc_d = SRC_AF_PRIV;
               fld_d = fld_q - 8'h01;
               if (fld_q == 8'h01)
                  st_d = S_AF_REST;
            end
            S_TS_PAY:
            begin
               oval_d = 1'b1;
               osrc_d = SRC_TS_PAY;
            end
            S_PES_HDR:
            begin
               // The prefix is checked byte by byte and, except for private stream two,
               // only trusted together with the marker bits that follow.
               idx_d = idx_q + 3'h1;
               if ((idx_q == 3'h1 && b != 8'h00) || (idx_q == 3'h2 && b != PREFIX_LAST))
               begin
                  st_d = S_DROP;
                  err_d = 1'b1;
               end
               if (idx_q == 3'h3)
                  sid_d = b;
               if (idx_q == 3'h5)
                  st_d = (sid_q == PS2_ID) ? S_PES_PAY : S_PES_F1;
            end
            S_PES_F1:
            begin
               st_d = (b[7:6] == PES_MARK) ? S_PES_F2 : S_DROP;
               err_d = (b[7:6] != PES_MARK);
            end
            S_PES_F2:
            begin
               f2_d = b;
               st_d = S_PES_HLEN;
            end
            S_PES_HLEN:
            begin
               sk = pes_skip(f2_q);
               nxt_d = f2_q[0] ? S_PES_EXT : S_PES_HREST;
               fld_d = sk;
               if (b == 8'h00)
                  st_d = S_PES_PAY;
               else
               begin
                  reg_d = 1'b1;
                  rem_d = {4'h0, b};
                  end_d = S_PES_PAY;
                  st_d = (sk != 8'h00) ? S_SKIP : nxt_d;
               end
            end
            S_PES_EXT:
            begin
               fld_d = PES_PRIV_LEN;
               st_d = b[7] ? S_PES_PRIV : S_PES_HREST;
            end
            S_PES_PRIV:
            begin
               oval_d = 1'b1;
               osrc_d = SRC_PES_HDR;
               fld_d = fld_q - 8'h01;
               if (fld_q == 8'h01)
                  st_d = S_PES_HREST;
            end
            S_PES_PAY:
            begin
               oval_d = (sid_q == PS1_ID) || (sid_q == PS2_ID);
               osrc_d = (sid_q == PS2_ID) ? SRC_PES2 : SRC_PES1;
            end
            S_SEC_HDR:
            begin
               idx_d = idx_q + 3'h1;
               if (idx_q == 3'h1)
               begin
                  syn_d = b[7];
                  hi_d = b[3:0];
               end
               else
               begin
                  reg_d = ({hi_q, b} != 12'h000);
                  rem_d = {hi_q, b};
                  end_d = S_IDLE;
                  nxt_d = S_SEC_PRIV;
                  fld_d = SEC_LONG_LEN;
                  st_d = !reg_d ? S_IDLE : (syn_q ? S_SKIP : S_SEC_PRIV);
               end
            end
            S_SEC_PRIV:
            begin
               if (syn_q && rem_q <= SEC_CRC_LEN)
                  st_d = S_SEC_CRC;
               else
               begin
                  oval_d = 1'b1;
                  osrc_d = SRC_SECT;
               end
            end
            S_DSC_TAG:
            begin
               dpriv_d = (b >= DESC_PRIV_MIN);
               st_d = S_DSC_LEN;
            end
            S_DSC_LEN:
            begin
               fld_d = b;
               st_d = (b == 8'h00) ? S_DSC_TAG : S_DSC_BODY;
            end
            S_DSC_BODY:
            begin
               oval_d = dpriv_q;
               osrc_d = SRC_DESC;
               fld_d = fld_q - 8'h01;
               if (fld_q == 8'h01)
                  st_d = S_DSC_TAG;
            end
            default: st_d = st_q;
         endcase
         // The enclosing length always wins over inner counts, so a bad
         // private length can never run past its field.
         if (reg_q && rem_q == 12'h001)
         begin
            st_d = end_q;
            reg_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_q <= S_IDLE;
         nxt_q <= S_IDLE;
         end_q <= S_IDLE;
         reg_q <= 1'b0;
         rem_q <= 12'h000;
         fld_q <= 8'h00;
         sid_q <= 8'h00;
         f2_q <= 8'h00;
         idx_q <= 3'h0;
         hi_q <= 4'h0;
         syn_q <= 1'b0;
         pay_q <= 1'b0;
         dpriv_q <= 1'b0;
         rdy_q <= 1'b0;
         odat_q <= 8'h00;
         oval_q <= 1'b0;
         osrc_q <= SRC_NONE;
         err_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         nxt_q <= nxt_d;
         end_q <= end_d;
         reg_q <= reg_d;
         rem_q <= rem_d;
         fld_q <= fld_d;
         sid_q <= sid_d;
         f2_q <= f2_d;
         idx_q <= idx_d;
         hi_q <= hi_d;
         syn_q <= syn_d;
         pay_q <= pay_d;
         dpriv_q <= dpriv_d;
         rdy_q <= 1'b1;
         odat_q <= odat_d;
         oval_q <= oval_d;
         osrc_q <= osrc_d;
         err_q <= err_d;
      end
   end
endmodule

// *** stream_source.sv ***
/*
 Stream source end: an AHB-Lite register slave that queues bytes in a FIFO and
 drains them onto the link. Assumes a single AHB master and one clock.
*/
`timescale 1ns/1ps

// --------------------------------------------------------------------------
// FIFO
// --------------------------------------------------------------------------
module sync_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset
   input wire logic in_valid, // push request
   output logic in_ready, // room available
   input wire logic [WIDTH-1:0] in_data, // pushed word
   output logic out_valid, // word available
   input wire logic out_ready, // pop request
   output logic [WIDTH-1:0] out_data, // head word
   output logic [$clog2(DEPTH):0] level // words held
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_chk
      $error("sync_fifo depth must be a power of two of at least 2");
   end

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rp_q];
   assign level = cnt_q;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb
   begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
      if (push)
         mem[wp_q] <= in_data;
   end
endmodule

// --------------------------------------------------------------------------
// Source end
// --------------------------------------------------------------------------
module stream_source #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk, // 20 MHz clock
   input wire logic rst_n, // sync reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always OKAY
   input wire logic hready, // bus ready
   ts_link_if.src lk // link toward the parser
);
   import ts_priv_pkg::*;
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   logic [31:0] hrdata_q, hrdata_d;
   logic hrdy_q, hrdy_d, pend_q, pend_d, wr_q, wr_d;
   logic [7:0] waddr_q, waddr_d;
   logic [1:0] ctrl_q, ctrl_d;
   logic sync_f_q, sync_f_d, pfx_f_q, pfx_f_d;
   logic [2:0] emu_q [2], emu_d [2];
   logic [1:0] pos_q, pos_d;
   logic [7:0] p1_q, p1_d, p2_q, p2_d;
   logic fin_ready, fout_valid, fout_ready, acc, push, drain;
   logic [ENTRY_W-1:0] fout_data;
   logic [LW-1:0] lvl;

   sync_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(pend_q),
      .in_ready(fin_ready),
      .in_data(hwdata[ENTRY_W-1:0]),
      .out_valid(fout_valid),
      .out_ready(fout_ready),
      .out_data(fout_data),
      .level(lvl)
   );

   // The link only moves while draining is enabled, so software can fill the
   // FIFO first and see the bus stall once it is full.
   assign fout_ready = lk.ready & ctrl_q[CTRL_EN_BIT];
   assign lk.valid = fout_valid & ctrl_q[CTRL_EN_BIT];
   assign lk.data = fout_data[7:0];
   assign lk.sop = fout_data[DATA_SOP_BIT];
   assign lk.kind = kind_e'(fout_data[DATA_KIND_LSB +: 2]);
   assign hrdata = hrdata_q;
   assign hreadyout = hrdy_q;
   assign hresp = 1'b0;
   assign acc = hsel & htrans[1] & hready;
   assign push = pend_q & fin_ready;
   assign drain = lk.valid & lk.ready;

   always_comb
   begin
      hrdata_d = hrdata_q;
      hrdy_d = hrdy_q;
      pend_d = pend_q;
      wr_d = 1'b0;
      waddr_d = waddr_q;
      ctrl_d = ctrl_q;
      sync_f_d = sync_f_q;
      pfx_f_d = pfx_f_q;
      emu_d = emu_q;
      pos_d = pos_q;
      p1_d = p1_q;
      p2_d = p2_q;
      // A data word write holds the bus until the FIFO takes it.
      if (push)
      begin
         pend_d = 1'b0;
         hrdy_d = 1'b1;
      end
      if (wr_q && waddr_q == ADDR_CTRL)
         ctrl_d = hwdata[1:0];
      if (wr_q && waddr_q == ADDR_STATUS)
      begin
         if (hwdata[ST_SYNC_BIT])
            sync_f_d = 1'b0;
         if (hwdata[ST_PREFIX_BIT])
            pfx_f_d = 1'b0;
      end
      if (acc)
      begin
         if (hwrite && haddr[7:0] == ADDR_DATA)
         begin
            pend_d = 1'b1;
            hrdy_d = 1'b0;
         end
         else if (hwrite)
         begin
            wr_d = 1'b1;
            waddr_d = haddr[7:0];
         end
         else
         begin
            case (haddr[7:0])
               ADDR_STATUS: hrdata_d = (32'(lvl) << ST_LEVEL_LSB)
                  | (32'(pfx_f_q) << ST_PREFIX_BIT) | (32'(sync_f_q) << ST_SYNC_BIT)
                  | (32'(!fin_ready) << ST_FULL_BIT) | (32'(!fout_valid) << ST_EMPTY_BIT);
               ADDR_CTRL: hrdata_d = 32'(ctrl_q);
               default: hrdata_d = 32'h0000_0000;
            endcase
         end
      end
      // Watch outgoing bytes; flags are set after the clear so a set wins.
      if (drain)
      begin
         pos_d = lk.sop ? 2'h1 : (pos_q == 2'h3 ? pos_q : pos_q + 2'h1);
         for (int i = 0; i < 2; i++)
         begin
            if (!lk.sop && lk.kind == KIND_TS && pos_q == 2'(i + 1))
            begin
               emu_d[i] = (lk.data == SYNC_BYTE) ? emu_q[i] + 3'h1 : 3'h0;
               if (lk.data == SYNC_BYTE && emu_q[i] == SYNC_EMU_MAX)
               begin
                  sync_f_d = 1'b1;
                  emu_d[i] = SYNC_EMU_MAX;
               end
            end
         end
         p1_d = lk.data;
         p2_d = p1_q;
         if (ctrl_q[CTRL_GUARD_BIT] && p2_q == 8'h00 && p1_q == 8'h00
             && lk.data == PREFIX_LAST)
            pfx_f_d = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         hrdata_q <= 32'h0000_0000;
         hrdy_q <= 1'b1;
         pend_q <= 1'b0;
         wr_q <= 1'b0;
         waddr_q <= 8'h00;
         ctrl_q <= CTRL_RESET;
         sync_f_q <= 1'b0;
         pfx_f_q <= 1'b0;
         emu_q <= '{3'h0, 3'h0};
         pos_q <= 2'h0;
         p1_q <= 8'hFF;
         p2_q <= 8'hFF;
      end
      else
      begin
         hrdata_q <= hrdata_d;
         hrdy_q <= hrdy_d;
         pend_q <= pend_d;
         wr_q <= wr_d;
         waddr_q <= waddr_d;
         ctrl_q <= ctrl_d;
         sync_f_q <= sync_f_d;
         pfx_f_q <= pfx_f_d;
         emu_q <= emu_d;
         pos_q <= pos_d;
         p1_q <= p1_d;
         p2_q <= p2_d;
      end
   end
endmodule

// *** ts_link_if.sv ***
/*
 Byte link between the stream source and the private data parser.
 Assumes both ends share one clock; a byte moves when valid and ready are high.
*/
`timescale 1ns/1ps
interface ts_link_if;
   import ts_priv_pkg::*;
   logic [7:0] data;
   logic valid;
   logic ready;
   logic sop;
   kind_e kind;
   modport src (output data, output valid, output sop, output kind, input ready);
   modport prs (input data, input valid, input sop, input kind, output ready);
endinterface

// *** ts_priv_pkg.sv ***
/*
 Shared constants and types for the private data locator pair: the stream
 source with its register port and the parser that extracts private bytes.
 Assumes one 20 MHz clock and a synchronous active-low reset on both ends.
*/
package ts_priv_pkg;

   // ----------------------------------------------------------------------
   // Stream syntax
   // ----------------------------------------------------------------------
   localparam logic [7:0] SYNC_BYTE = 8'h47;
   localparam logic [7:0] AF_LEN_MAX = 8'hB7;
   localparam logic [7:0] PES_PRIV_LEN = 8'h10;
   localparam logic [7:0] PREFIX_LAST = 8'h01;
   localparam logic [7:0] PS1_ID = 8'hBD;
   localparam logic [7:0] PS2_ID = 8'hBF;
   localparam logic [7:0] DESC_PRIV_MIN = 8'h40;
   localparam logic [1:0] PES_MARK = 2'h2;
   localparam logic [7:0] PCR_LEN = 8'h06;
   localparam logic [7:0] SPLICE_LEN = 8'h01;
   localparam logic [7:0] PTS_LEN = 8'h05;
   localparam logic [7:0] PTS_DTS_LEN = 8'h0A;
   localparam logic [7:0] ESCR_LEN = 8'h06;
   localparam logic [7:0] ES_RATE_LEN = 8'h03;
   localparam logic [7:0] TRICK_LEN = 8'h01;
   localparam logic [7:0] COPY_LEN = 8'h01;
   localparam logic [7:0] PES_CRC_LEN = 8'h02;
   localparam logic [7:0] SEC_LONG_LEN = 8'h05;
   localparam logic [11:0] SEC_CRC_LEN = 12'h004;
   localparam logic [2:0] SYNC_EMU_MAX = 3'h4;

   // ----------------------------------------------------------------------
   // Source register map and fields
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam int DATA_SOP_BIT = 8;
   localparam int DATA_KIND_LSB = 9;
   localparam int ENTRY_W = 11;
   localparam int ST_EMPTY_BIT = 0;
   localparam int ST_FULL_BIT = 1;
   localparam int ST_SYNC_BIT = 2;
   localparam int ST_PREFIX_BIT = 3;
   localparam int ST_LEVEL_LSB = 8;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_GUARD_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;

   typedef enum logic [1:0] {KIND_TS, KIND_PES, KIND_SEC, KIND_DSC} kind_e;
   typedef enum logic [2:0] {
      SRC_NONE, SRC_TS_PAY, SRC_AF_PRIV, SRC_PES_HDR,
      SRC_PES1, SRC_PES2, SRC_DESC, SRC_SECT
   } src_e;

endpackage

// *** ts_priv_properties.sv ***
/*
 Checker for the link between the stream source and the parser, and for the
 parser outputs. Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ts_priv_properties (
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset, active low
   input wire logic [7:0] data, // link byte
   input wire logic valid, // byte offered
   input wire logic ready, // byte accepted
   input wire logic sop, // first byte of a unit
   input wire ts_priv_pkg::kind_e kind, // unit type
   input wire logic [7:0] priv_data, // extracted byte
   input wire logic priv_valid, // byte strobe
   input wire ts_priv_pkg::src_e priv_src, // carriage location
   input wire logic frame_err // unit error
);
   import ts_priv_pkg::*;
   // ----------
   // Byte position in the current unit
   // ----------
   logic [7:0] pos_q, pos_d, cur;
   kind_e kind_q, kind_d;
   always_comb
   begin
      cur = sop ? 8'h00 : pos_q + 8'h01;
      pos_d = (valid && ready) ? cur : pos_q;
      kind_d = (valid && ready && sop) ? kind : kind_q;
   end
   always_ff @(posedge clk)
   begin
      pos_q <= rst_n ? pos_d : 8'h00;
      kind_q <= rst_n ? kind_d : KIND_TS;
   end
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence took;
      valid && ready;
   endsequence
   sequence af_too_long;
      took ##0 (kind_q == KIND_TS && !sop && cur == 8'h04 && data > AF_LEN_MAX);
   endsequence
   AST_READY_HOLD: assert property (ready |=> ready)
      else $error("link ready dropped");
   AST_BYTE_ECHO: assert property (priv_valid |-> $past(valid && ready) && $past(data) == priv_data)
      else $error("private byte not the byte taken");
   AST_SRC_KNOWN: assert property (priv_valid |-> priv_src != SRC_NONE)
      else $error("private byte without location");
   AST_ERR_CAUSE: assert property (frame_err |-> $past(valid && ready))
      else $error("error without a taken byte");
   AST_PREFIX_BAD: assert property (took ##0 (sop && kind == KIND_PES && data != 8'h00) |=> frame_err)
      else $error("bad prefix not flagged");
   AST_AF_LONG: assert property (af_too_long |=> frame_err)
      else $error("long adaptation field not flagged");
   AST_PES2_HDR: assert property (priv_valid && priv_src == SRC_PES2 |-> $past(cur) > 8'h05)
      else $error("stream two header byte emitted");
   AST_SECT_HDR: assert property (priv_valid && priv_src == SRC_SECT |-> $past(cur) > 8'h02)
      else $error("section header byte emitted");
   AST_DESC_BODY: assert property (priv_valid && priv_src == SRC_DESC |-> $past(cur) > 8'h01)
      else $error("descriptor tag or length emitted");
endmodule

// *** ts_private_data_locator_test.sv ***
/*
 Testbench: writes units through the source over AHB-Lite and checks the
 private bytes the parser emits. Assumes the pair joined by ts_link_if.
*/
`timescale 1ns/1ps
module ts_private_data_locator_test;
   import ts_priv_pkg::*;
   logic clk, rst_n, hwrite, hreadyout, hresp, priv_valid, frame_err;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [7:0] priv_data;
   src_e priv_src;
   logic [10:0] got[$], exp[$];
   int fails, cmp_count, errs;
   ts_link_if ts_link_if_i ();
   stream_source stream_source_i (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .hready(hreadyout), .lk(ts_link_if_i));
   private_parser private_parser_i (.clk(clk), .rst_n(rst_n), .lk(ts_link_if_i),
      .priv_data(priv_data), .priv_valid(priv_valid), .priv_src(priv_src), .frame_err(frame_err));
   ts_priv_properties ts_priv_properties_i (.clk(clk), .rst_n(rst_n), .data(ts_link_if_i.data),
      .valid(ts_link_if_i.valid), .ready(ts_link_if_i.ready), .sop(ts_link_if_i.sop),
      .kind(ts_link_if_i.kind), .priv_data(priv_data), .priv_valid(priv_valid),
      .priv_src(priv_src), .frame_err(frame_err));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Outputs change only at rising edges, so the falling edge sees each pulse once.
   always @(negedge clk)
   begin
      if (priv_valid === 1'b1) got.push_back({priv_src, priv_data});
      if (frame_err === 1'b1) errs++;
   end
   // ----------
   // Tasks
   // ----------
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("BAD t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic r;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do begin @(negedge clk); r = hreadyout; @(posedge clk); end while (r !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(negedge clk); r = hreadyout; q = hrdata; @(posedge clk); end while (r !== 1'b1);
   endtask
   task unit(input kind_e k, input logic [7:0] b[$]);
      foreach (b[i]) bus(1'b1, ADDR_DATA, {21'h000000, k, i == 0, b[i]});
   endtask
   task want(input src_e s, input logic [7:0] b[$]);
      foreach (b[i]) exp.push_back({s, b[i]});
   endtask
   task done(input string name, input int e);
      do bus(1'b0, ADDR_STATUS, 32'h0); while (q[ST_EMPTY_BIT] !== 1'b1);
      repeat (3) @(posedge clk);
      chk(got.size(), exp.size());
      foreach (exp[i]) chk(got[i], exp[i]);
      chk(errs, e);
      got.delete();
      exp.delete();
      errs = 0;
      $display("test %s finished", name);
   endtask
   task report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      report_and_stop;
   end
   // ----------
   // Tests
   // ----------
   initial
   begin
      logic [7:0] b[$], pv[$];
      rst_n = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
      fails = 0; cmp_count = 0; errs = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk(q, 32'h1);
      bus(1'b0, 8'h0C, 32'h0);
      chk(q, 32'h0);
      chk(hresp, 32'h0);
      bus(1'b1, ADDR_CTRL, 32'h0);
      unit(KIND_PES, '{8'h00, 8'h00, 8'h01, 8'hBF, 8'h00, 8'h02, 8'hD1, 8'hD2});
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(q, 32'h802);
      bus(1'b1, ADDR_CTRL, 32'h3);
      want(SRC_PES2, '{8'hD1, 8'hD2});
      done("stream two", 0);
      chk(q, 32'h9);
      unit(KIND_TS, '{8'h47, 8'h00, 8'h00, 8'h30, 8'h03, 8'h02, 8'h01, 8'hAA, 8'h55, 8'h66});
      want(SRC_AF_PRIV, '{8'hAA});
      want(SRC_TS_PAY, '{8'h55, 8'h66});
      done("ts private", 0);
      unit(KIND_TS, '{8'h47, 8'h00, 8'h00, 8'h30, 8'h03, 8'h00, 8'hFF, 8'hFF, 8'h77});
      want(SRC_TS_PAY, '{8'h77});
      done("ts flag clear", 0);
      unit(KIND_TS, '{8'h47, 8'h00, 8'h00, 8'h30, 8'hB8, 8'h02, 8'h01, 8'hAA});
      done("adaptation too long", 1);
      b = '{8'h00, 8'h00, 8'h01, 8'hBD, 8'h00, 8'h15, 8'h80, 8'h01, 8'h11, 8'h80};
      for (int i = 0; i < 16; i++) pv.push_back(8'hE0 + i[7:0]);
      b = {b, pv, 8'hC0};
      unit(KIND_PES, b);
      want(SRC_PES_HDR, pv);
      want(SRC_PES1, '{8'hC0});
      done("stream one", 0);
      unit(KIND_PES, '{8'h01, 8'h00, 8'h01, 8'hBD});
      unit(KIND_PES, '{8'h00, 8'h00, 8'h01, 8'hBF, 8'h00, 8'h04, 8'h00, 8'h00, 8'h01, 8'hBD});
      want(SRC_PES2, '{8'h00, 8'h00, 8'h01, 8'hBD});
      done("prefix emulation", 1);
      unit(KIND_DSC, '{8'h3F, 8'h01, 8'hEE, 8'h40, 8'h02, 8'hE1, 8'hE2, 8'hFF, 8'h01, 8'hE3});
      want(SRC_DESC, '{8'hE1, 8'hE2, 8'hE3});
      done("descriptors", 0);
      unit(KIND_SEC, '{8'h80, 8'h00, 8'h02, 8'hA1, 8'hA2});
      unit(KIND_SEC, '{8'h80, 8'hB0, 8'h0A, 8'h00, 8'h01, 8'hC1, 8'h00, 8'h00, 8'hA3,
         8'hCC, 8'hCC, 8'hCC, 8'hCC});
      want(SRC_SECT, '{8'hA1, 8'hA2, 8'hA3});
      done("sections", 0);
      report_and_stop;
   end
endmodule
